// ==== wiper_lut_mode_control.sv ====
// wiper update-mode control: control registers, table, wiper and index logic
`timescale 1ns/1ps
module wiper_lut_mode_control #(
	parameter int TABLE_DEPTH = 36,
	parameter int INDEX_W     = 6
) (
	// clock and reset
	input  wire logic               clk_i,
	input  wire logic               rst_n_i,
	// byte register port from the serial front end
	input  wire logic               reg_wr_i,
	input  wire logic [7:0]         reg_addr_i,
	input  wire logic [7:0]         reg_wdata_i,
	output logic      [7:0]         reg_rdata_o,
	// nonvolatile write request
	output logic                    ee_wr_o,
	output logic      [7:0]         ee_addr_o,
	output logic      [7:0]         ee_data_o,
	// temperature conversion result
	input  wire logic               conv_done_i,
	input  wire logic [INDEX_W-1:0] conv_index_i,
	// address straps
	input  wire logic               address_strap_low_i,
	input  wire logic               address_strap_high_i,
	output logic      [6:0]         slave_addr_o,
	// potentiometer side
	output logic      [6:0]         wiper_o,
	output logic      [INDEX_W-1:0] table_index_o,
	output logic      [1:0]         mode_o,
	output logic                    standby_o
);

	//------------------------------------------------------------------
	// functions
	//------------------------------------------------------------------
	function automatic wiper_lut_pkg::mode_e f_mode(input logic [7:0] r);
		if (!r[wiper_lut_pkg::BIT_UPDATE_MODE])
			return wiper_lut_pkg::MODE_DEFAULT;
		else if (r[wiper_lut_pkg::BIT_ADDER_MODE])
			return wiper_lut_pkg::MODE_ADDER;
		else
			return wiper_lut_pkg::MODE_TABLE;
	endfunction

	// signed offset on unsigned base, saturated to the wiper range
	function automatic logic [6:0] f_sum_clamp(input logic [6:0] base, input logic [7:0] ofs);
		logic signed [8:0] s;
		s = $signed({2'b00, base}) + $signed({ofs[7], ofs});
		if (s[8])
			return wiper_lut_pkg::WIPER_MIN;
		else if (s[7])
			return wiper_lut_pkg::WIPER_MAX;
		else
			return s[6:0];
	endfunction

	// out-of-range index points at the last entry
	function automatic logic [INDEX_W-1:0] f_idx(input logic [7:0] v);
		if (int'(v) >= TABLE_DEPTH)
			return INDEX_W'(TABLE_DEPTH - 1);
		else
			return v[INDEX_W-1:0];
	endfunction

	//------------------------------------------------------------------
	// state
	//------------------------------------------------------------------
	logic [7:0]                shadow_write_control_r;
	logic [7:0]                operating_mode_select_r;
	logic [7:0]                update_and_standby_control_r;
	logic [6:0]                initial_wiper_value_r;
	logic [6:0]                wiper_r;
	logic [INDEX_W-1:0]        table_index_r;
	logic [7:0]                table_mem [TABLE_DEPTH];
	logic [7:0]                rdata_r;
	logic                      ee_wr_r;
	logic [7:0]                ee_addr_r;
	logic [7:0]                ee_data_r;
	logic [1:0]                strap_low_sync_r;
	logic [1:0]                strap_high_sync_r;
	logic [6:0]                slave_addr_r;
	wiper_lut_pkg::run_state_e run_r;
	wiper_lut_pkg::run_state_e run_nxt;

	wiper_lut_pkg::mode_e      mode;
	logic                      table_mode;
	logic                      temp_dis_eff;
	logic                      index_dis_eff;
	logic                      standby_bit;
	logic                      shadow_only;
	logic                      conv_take;
	logic [INDEX_W-1:0]        index_next;
	logic [7:0]                table_entry_value;
	logic [6:0]                wiper_load;
	logic                      tbl_hit;
	logic [INDEX_W-1:0]        tbl_sel;
	logic                      wr_init;
	logic                      wr_mode;
	logic                      wr_wiper;
	logic                      wr_index;

	//------------------------------------------------------------------
	// decode
	//------------------------------------------------------------------
	assign mode          = f_mode(operating_mode_select_r);
	assign table_mode    = (mode != wiper_lut_pkg::MODE_DEFAULT);
	// disable bits only count in the table modes
	assign temp_dis_eff  = table_mode
		&& update_and_standby_control_r[wiper_lut_pkg::BIT_TEMP_DIS];
	assign index_dis_eff = table_mode
		&& update_and_standby_control_r[wiper_lut_pkg::BIT_INDEX_DIS];
	assign standby_bit   = update_and_standby_control_r[wiper_lut_pkg::BIT_STANDBY];
	assign shadow_only   = shadow_write_control_r[wiper_lut_pkg::BIT_SHADOW_OFF];
	assign conv_take  = conv_done_i && table_mode && (run_r == wiper_lut_pkg::RUN_ACTIVE);
	assign index_next = index_dis_eff ? table_index_r : f_idx(8'(conv_index_i));
	assign table_entry_value = table_mem[index_next];
	assign wiper_load = (mode == wiper_lut_pkg::MODE_ADDER)
		? f_sum_clamp(initial_wiper_value_r, table_entry_value)
		: (table_entry_value[7] ? wiper_lut_pkg::WIPER_MAX : table_entry_value[6:0]);
	assign tbl_hit  = (reg_addr_i >= wiper_lut_pkg::ADDR_TABLE_BASE)
		&& (int'(reg_addr_i) < int'(wiper_lut_pkg::ADDR_TABLE_BASE) + TABLE_DEPTH);
	assign tbl_sel  = INDEX_W'(reg_addr_i - wiper_lut_pkg::ADDR_TABLE_BASE);
	assign wr_init  = reg_wr_i && (reg_addr_i == wiper_lut_pkg::ADDR_INIT_WIPER);
	assign wr_mode  = reg_wr_i && (reg_addr_i == wiper_lut_pkg::ADDR_MODE);
	assign wr_wiper = reg_wr_i && (reg_addr_i == wiper_lut_pkg::ADDR_WIPER) && temp_dis_eff;
	assign wr_index = reg_wr_i && (reg_addr_i == wiper_lut_pkg::ADDR_INDEX) && index_dis_eff;

	//------------------------------------------------------------------
	// control registers
	//------------------------------------------------------------------
	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			shadow_write_control_r       <= wiper_lut_pkg::RST_CTRL;
			operating_mode_select_r      <= wiper_lut_pkg::RST_CTRL;
			update_and_standby_control_r <= wiper_lut_pkg::RST_CTRL;
		end else if (reg_wr_i) begin
			// reserved bits never stored
			if (reg_addr_i == wiper_lut_pkg::ADDR_SHADOW)
				shadow_write_control_r <= reg_wdata_i & wiper_lut_pkg::MASK_SHADOW;
			if (wr_mode)
				operating_mode_select_r <= reg_wdata_i & wiper_lut_pkg::MASK_MODE;
			if (reg_addr_i == wiper_lut_pkg::ADDR_UPDATE)
				update_and_standby_control_r <= reg_wdata_i & wiper_lut_pkg::MASK_UPDATE;
		end
	end

	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i)
			initial_wiper_value_r <= wiper_lut_pkg::RST_INIT_WIPER;
		else if (wr_init)
			initial_wiper_value_r <= reg_wdata_i[6:0];
	end

	// nonvolatile array lives in the shadow copy here; programming is external
	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			for (int i = 0; i < TABLE_DEPTH; i++)
				table_mem[i] <= wiper_lut_pkg::RST_TABLE;
		end else if (reg_wr_i && tbl_hit) begin
			table_mem[tbl_sel] <= reg_wdata_i;
		end
	end

	// initial-value and mode writes also go to nonvolatile storage unless shadow-only is set; table writes always do
	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			ee_wr_r   <= 1'b0;
			ee_addr_r <= wiper_lut_pkg::RD_ZERO;
			ee_data_r <= wiper_lut_pkg::RD_ZERO;
		end else begin
			ee_wr_r <= ((wr_init || wr_mode) && !shadow_only) || (reg_wr_i && tbl_hit);
			if (reg_wr_i) begin
				ee_addr_r <= reg_addr_i;
				ee_data_r <= wr_mode ? (reg_wdata_i & wiper_lut_pkg::MASK_MODE) : reg_wdata_i;
			end
		end
	end

	//------------------------------------------------------------------
	// run state: standby and resume
	//------------------------------------------------------------------
	always_comb begin
		run_nxt = run_r;
		unique case (run_r)
			wiper_lut_pkg::RUN_ACTIVE:  if (standby_bit) run_nxt = wiper_lut_pkg::RUN_STANDBY;
			wiper_lut_pkg::RUN_STANDBY: if (!standby_bit) run_nxt = wiper_lut_pkg::RUN_RESUME;
			wiper_lut_pkg::RUN_RESUME: begin
				// first result after wake may come from a partial conversion
				if (standby_bit)
					run_nxt = wiper_lut_pkg::RUN_STANDBY;
				else if (conv_done_i)
					run_nxt = wiper_lut_pkg::RUN_ACTIVE;
			end
			default: run_nxt = wiper_lut_pkg::RUN_STANDBY;
		endcase
	end

	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i)
			run_r <= wiper_lut_pkg::RUN_ACTIVE;
		else
			run_r <= run_nxt;
	end

	//------------------------------------------------------------------
	// wiper and index
	//------------------------------------------------------------------
	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i)
			wiper_r <= wiper_lut_pkg::RST_INIT_WIPER;
		else if (wr_init && !table_mode)
			wiper_r <= reg_wdata_i[6:0];
		else if (wr_wiper)
			wiper_r <= reg_wdata_i[6:0];
		else if (conv_take && !temp_dis_eff)
			wiper_r <= wiper_load;
	end

	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i)
			table_index_r <= '0;
		else if (wr_index)
			table_index_r <= f_idx(reg_wdata_i);
		else if (conv_take && !index_dis_eff)
			table_index_r <= index_next;
	end

	//------------------------------------------------------------------
	// read data, one cycle after the address
	//------------------------------------------------------------------
	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			rdata_r <= wiper_lut_pkg::RD_ZERO;
		end else begin
			rdata_r <= wiper_lut_pkg::RD_ZERO;
			if (tbl_hit)
				rdata_r <= table_mem[tbl_sel];
			else case (reg_addr_i)
				wiper_lut_pkg::ADDR_INIT_WIPER:
					rdata_r <= {1'b0, table_mode ? initial_wiper_value_r : wiper_r};
				wiper_lut_pkg::ADDR_SHADOW: rdata_r <= shadow_write_control_r;
				wiper_lut_pkg::ADDR_MODE:   rdata_r <= operating_mode_select_r;
				wiper_lut_pkg::ADDR_UPDATE: rdata_r <= update_and_standby_control_r;
				wiper_lut_pkg::ADDR_INDEX:  if (table_mode) rdata_r <= 8'(table_index_r);
				wiper_lut_pkg::ADDR_WIPER:  if (table_mode) rdata_r <= {1'b0, wiper_r};
				default:                    rdata_r <= wiper_lut_pkg::RD_ZERO;
			endcase
		end
	end

	//------------------------------------------------------------------
	// address straps
	//------------------------------------------------------------------
	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			strap_low_sync_r  <= 2'b00;
			strap_high_sync_r <= 2'b00;
			slave_addr_r      <= wiper_lut_pkg::SLAVE_ADDR_BASE;
		end else begin
			strap_low_sync_r  <= {strap_low_sync_r[0], address_strap_low_i};
			strap_high_sync_r <= {strap_high_sync_r[0], address_strap_high_i};
			slave_addr_r      <= wiper_lut_pkg::SLAVE_ADDR_BASE
				| {5'h00, strap_high_sync_r[1], strap_low_sync_r[1]};
		end
	end

	assign reg_rdata_o   = rdata_r;
	assign ee_wr_o       = ee_wr_r;
	assign ee_addr_o     = ee_addr_r;
	assign ee_data_o     = ee_data_r;
	assign slave_addr_o  = slave_addr_r;
	assign wiper_o       = wiper_r;
	assign table_index_o = table_index_r;
	assign mode_o        = mode;
	assign standby_o     = (run_r == wiper_lut_pkg::RUN_STANDBY);

	//------------------------------------------------------------------
	// assertions
	//------------------------------------------------------------------
	default clocking @(posedge clk_i); endclocking
	default disable iff (!rst_n_i);

	property p_adder_sel;
		operating_mode_select_r[1:0] == 2'b11 |-> mode_o == wiper_lut_pkg::MODE_ADDER;
	endproperty
	a_adder_sel: assert property (p_adder_sel) else $error("adder mode not selected");

	property p_adder_load;
		conv_take && mode == wiper_lut_pkg::MODE_ADDER && !temp_dis_eff && !reg_wr_i
			|=> wiper_o == f_sum_clamp($past(initial_wiper_value_r), $past(table_entry_value));
	endproperty
	a_adder_load: assert property (p_adder_load) else $error("adder load wrong");

	property p_shadow_only;
		wr_init && shadow_only |=> !ee_wr_o;
	endproperty
	a_shadow_only: assert property (p_shadow_only) else $error("shadow-only wrote storage");

	property p_default_still;
		mode == wiper_lut_pkg::MODE_DEFAULT && conv_done_i && !reg_wr_i
			|=> $stable(wiper_o) && $stable(table_index_o);
	endproperty
	a_default_still: assert property (p_default_still) else $error("default mode moved");

	property p_temp_dis;
		conv_take && temp_dis_eff && !reg_wr_i |=> $stable(wiper_o);
	endproperty
	a_temp_dis: assert property (p_temp_dis) else $error("wiper loaded while disabled");

	property p_index_upd;
		conv_take && !index_dis_eff |=> table_index_o == f_idx(8'($past(conv_index_i)));
	endproperty
	a_index_upd: assert property (p_index_upd) else $error("index not updated");

	property p_standby_hold;
		standby_o && !reg_wr_i |=> $stable(wiper_o) && $stable(table_index_o);
	endproperty
	a_standby_hold: assert property (p_standby_hold) else $error("standby moved wiper");

	property p_resume_skip;
		run_r == wiper_lut_pkg::RUN_RESUME && conv_done_i && !standby_bit && !reg_wr_i
			|=> $stable(wiper_o) ##1 !standby_o;
	endproperty
	a_resume_skip: assert property (p_resume_skip) else $error("resume too early");

	property p_slave_addr;
		strap_low_sync_r[1] == 1'b0 && strap_high_sync_r[1] == 1'b0
			|=> slave_addr_o == wiper_lut_pkg::SLAVE_ADDR_BASE;
	endproperty
	a_slave_addr: assert property (p_slave_addr) else $error("slave address wrong");

	property p_reserved_zero;
		wr_mode |=> operating_mode_select_r[7:2] == 6'h00;
	endproperty
	a_reserved_zero: assert property (p_reserved_zero) else $error("reserved bits kept");

	c_adder_load: cover property (conv_take && mode == wiper_lut_pkg::MODE_ADDER);
	c_standby:    cover property (standby_o ##[1:20] run_r == wiper_lut_pkg::RUN_RESUME);
	c_manual:     cover property (wr_wiper);
endmodule

// ==== wiper_lut_pkg.sv ====
// constants, field layout and modes of the wiper table-mode control block
//----------------------------------------------------------------------
//----------------------------------------------------------------------
package wiper_lut_pkg;
	localparam logic [7:0] ADDR_INIT_WIPER = 8'h00;
	localparam logic [7:0] ADDR_SHADOW     = 8'h02;
	localparam logic [7:0] ADDR_MODE       = 8'h03;
	localparam logic [7:0] ADDR_INDEX      = 8'h08;
	localparam logic [7:0] ADDR_WIPER      = 8'h09;
	localparam logic [7:0] ADDR_UPDATE     = 8'h0A;
	localparam logic [7:0] ADDR_TABLE_BASE = 8'h80;

	localparam logic [7:0] RST_CTRL        = 8'h00;
	localparam logic [7:0] RST_TABLE       = 8'h00;
	localparam logic [6:0] RST_INIT_WIPER  = 7'h40;
	localparam logic [7:0] RD_ZERO         = 8'h00;

	localparam logic [7:0] MASK_SHADOW     = 8'h80;
	localparam logic [7:0] MASK_MODE       = 8'h03;
	localparam logic [7:0] MASK_UPDATE     = 8'h07;

	localparam int BIT_SHADOW_OFF  = 7;
	localparam int BIT_UPDATE_MODE = 0;
	localparam int BIT_ADDER_MODE  = 1;
	localparam int BIT_TEMP_DIS    = 2;
	localparam int BIT_INDEX_DIS   = 1;
	localparam int BIT_STANDBY     = 0;

	localparam logic [6:0] WIPER_MAX       = 7'h7F;
	localparam logic [6:0] WIPER_MIN       = 7'h00;
	localparam logic [6:0] SLAVE_ADDR_BASE = 7'h28;

	typedef enum logic [1:0] {
		MODE_DEFAULT = 2'b00,
		MODE_TABLE   = 2'b01,
		MODE_ADDER   = 2'b11
	} mode_e;

	typedef enum logic [1:0] {
		RUN_ACTIVE  = 2'b00,
		RUN_STANDBY = 2'b01,
		RUN_RESUME  = 2'b10
	} run_state_e;
endpackage

// ==== reg_master_model.sv ====
// byte register master standing in for the serial front end
`timescale 1ns/1ps
module reg_master_model (
	// clock
	input  wire logic       clk_i,
	// byte register port
	output logic            reg_wr_o,
	output logic [7:0]      reg_addr_o,
	output logic [7:0]      reg_wdata_o,
	input  wire logic [7:0] reg_rdata_i
);
	initial begin
		reg_wr_o = 1'b0;
		reg_addr_o = 8'hFF;
		reg_wdata_o = 8'h00;
	end

	// enter just after a rising edge; a spare edge keeps the strobe from re-rising at once
	task automatic write_reg(input logic [7:0] a, input logic [7:0] d);
		reg_wr_o = 1'b1;
		reg_addr_o = a;
		reg_wdata_o = d;
		@(posedge clk_i);
		#1;
		reg_wr_o = 1'b0;
		reg_wdata_o = ~d;
		@(posedge clk_i);
		#1;
	endtask

	// read data is registered from the address seen at the edge
	task automatic read_reg(input logic [7:0] a, output logic [7:0] d);
		reg_addr_o = a;
		@(posedge clk_i);
		#1;
		d = reg_rdata_i;
	endtask
endmodule

// ==== test_wiper_lut_mode_control.sv ====
// self-checking bench of the wiper table-mode control block
`timescale 1ns/1ps
module test_wiper_lut_mode_control;
	logic       clk_i;
	logic       rst_n_i;
	logic       reg_wr_i;
	logic [7:0] reg_addr_i;
	logic [7:0] reg_wdata_i;
	logic [7:0] reg_rdata_o;
	logic       ee_wr_o;
	logic [7:0] ee_addr_o;
	logic [7:0] ee_data_o;
	logic       conv_done_i;
	logic [5:0] conv_index_i;
	logic       address_strap_low_i;
	logic       address_strap_high_i;
	logic [6:0] slave_addr_o;
	logic [6:0] wiper_o;
	logic [5:0] table_index_o;
	logic [1:0] mode_o;
	logic       standby_o;
	logic [7:0] tbl [36];
	logic [6:0] initial_wiper_value;
	logic [6:0] wip;
	logic [5:0] idx;
	logic [7:0] rv;
	int         error_cnt;
	int         checked;
	int         ee_cnt = 0;
	int         e0;

	wiper_lut_mode_control u_wiper_lut_mode_control (
		.clk_i               (clk_i),
		.rst_n_i             (rst_n_i),
		.reg_wr_i            (reg_wr_i),
		.reg_addr_i          (reg_addr_i),
		.reg_wdata_i         (reg_wdata_i),
		.reg_rdata_o         (reg_rdata_o),
		.ee_wr_o             (ee_wr_o),
		.ee_addr_o           (ee_addr_o),
		.ee_data_o           (ee_data_o),
		.conv_done_i         (conv_done_i),
		.conv_index_i        (conv_index_i),
		.address_strap_low_i (address_strap_low_i),
		.address_strap_high_i(address_strap_high_i),
		.slave_addr_o        (slave_addr_o),
		.wiper_o             (wiper_o),
		.table_index_o       (table_index_o),
		.mode_o              (mode_o),
		.standby_o           (standby_o)
	);

	reg_master_model u_reg_master_model (
		.clk_i      (clk_i),
		.reg_wr_o   (reg_wr_i),
		.reg_addr_o (reg_addr_i),
		.reg_wdata_o(reg_wdata_i),
		.reg_rdata_i(reg_rdata_o)
	);

	initial begin
		clk_i = 1'b0;
		forever #25 clk_i = ~clk_i;
	end

	// pulses counted mid-cycle, away from the launching edge
	always @(negedge clk_i) begin
		if (ee_wr_o === 1'b1)
			ee_cnt++;
	end

	//----------------------------------------------------------------
	// helpers
	//----------------------------------------------------------------
	function automatic logic [6:0] load(input logic [7:0] e, input logic [6:0] iv, input logic add);
		int s;
		s = int'(iv) + int'($signed(e));
		if (!add)
			return e[7] ? 7'h7F : e[6:0];
		return (s < 0) ? 7'h00 : (s > 127) ? 7'h7F : 7'(s);
	endfunction

	task automatic give_verdict;
		if (error_cnt == 0 && checked > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask

	task automatic chk(input logic [7:0] got, input logic [7:0] exp);
		checked++;
		if (got !== exp) begin
			error_cnt++;
			$display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask

	task automatic chk_out;
		chk({1'b0, wiper_o}, {1'b0, wip});
		chk({2'b00, table_index_o}, {2'b00, idx});
	endtask

	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		u_reg_master_model.write_reg(a, d);
	endtask

	task automatic rd_chk(input logic [7:0] a, input logic [7:0] exp);
		logic [7:0] d;
		u_reg_master_model.read_reg(a, d);
		chk(d, exp);
	endtask

	task automatic conv(input logic [5:0] i);
		conv_done_i = 1'b1;
		conv_index_i = i;
		@(posedge clk_i);
		#1;
		conv_done_i = 1'b0;
		conv_index_i = ~i;
		@(posedge clk_i);
		#1;
	endtask

	initial begin
		repeat (100000) @(posedge clk_i);
		error_cnt++;
		give_verdict();
	end

	//----------------------------------------------------------------
	// main sequence
	//----------------------------------------------------------------
	initial begin
		error_cnt = 0;
		checked = 0;
		rst_n_i = 1'b0;
		conv_done_i = 1'b0;
		conv_index_i = 6'h00;
		address_strap_low_i = 1'b0;
		address_strap_high_i = 1'b0;
		idx = 6'h00;
		wip = 7'h40;
		void'($urandom(32'hEE99326B));
		repeat (10) @(posedge clk_i);
		#1;
		rst_n_i = 1'b1;
		rd_chk(8'h02, 8'h00);
		rd_chk(8'h03, 8'h00);
		rd_chk(8'h0A, 8'h00);
		rd_chk(8'h00, 8'h40);
		rd_chk(8'h50, 8'h00);
		chk_out();
		for (int s = 0; s < 4; s++) begin
			{address_strap_high_i, address_strap_low_i} = s[1:0];
			repeat (4) @(posedge clk_i);
			#1;
			chk({slave_addr_o, 1'b0}, 8'h50 | 8'(s << 1));
		end
		wr(8'h02, 8'hFF);
		rd_chk(8'h02, 8'h80);
		wr(8'h03, 8'hFF);
		rd_chk(8'h03, 8'h03);
		wr(8'h0A, 8'hF8);
		rd_chk(8'h0A, 8'h00);
		wr(8'h02, 8'h00);
		for (int m = 0; m < 4; m++) begin
			wr(8'h03, 8'(m));
			chk({6'h00, mode_o}, m[0] ? {6'h00, m[1], 1'b1} : 8'h00);
		end
		wr(8'h03, 8'h00);
		// default mode: the initial-value write moves the wiper as well
		initial_wiper_value = 7'($urandom_range(1, 126));
		wip = initial_wiper_value;
		e0 = ee_cnt;
		wr(8'h00, {1'b0, initial_wiper_value});
		chk(8'(ee_cnt - e0), 8'h01);
		chk(ee_data_o, {1'b0, initial_wiper_value});
		chk_out();
		wr(8'h02, 8'h80);
		e0 = ee_cnt;
		wr(8'h00, 8'h11);
		chk(8'(ee_cnt - e0), 8'h00);
		wr(8'h02, 8'h00);
		wr(8'h00, {1'b0, initial_wiper_value});
		// extreme entries at both ends drive the clamp
		for (int i = 0; i < 36; i++) begin
			tbl[i] = (i == 0) ? 8'h80 : (i == 35) ? 8'h7F : 8'($urandom);
			wr(8'h80 + 8'(i), tbl[i]);
		end
		chk(ee_addr_o, 8'hA3);
		chk(ee_data_o, tbl[35]);
		conv(6'h14);
		chk_out();
		for (int md = 1; md < 4; md += 2) begin
			wr(8'h03, 8'(md));
			chk_out();
			for (int k = 0; k < 12; k++) begin
				rv = (k == 0) ? 8'h00 : (k == 1) ? 8'h23 : (k == 2) ? 8'h3F : 8'($urandom);
				conv(rv[5:0]);
				idx = (rv[5:0] > 6'h23) ? 6'h23 : rv[5:0];
				wip = load(tbl[idx], initial_wiper_value, md[1]);
				chk_out();
			end
		end
		initial_wiper_value = 7'($urandom_range(1, 126));
		wr(8'h00, {1'b0, initial_wiper_value});
		chk_out();
		rd_chk(8'h00, {1'b0, initial_wiper_value});
		rd_chk(8'h09, {1'b0, wip});
		wr(8'h0A, 8'h04);
		rv = 8'($urandom_range(0, 35));
		conv(rv[5:0]);
		idx = rv[5:0];
		chk_out();
		wr(8'h09, 8'h5A);
		wip = 7'h5A;
		chk_out();
		wr(8'h0A, 8'h02);
		wr(8'h08, 8'h23);
		idx = 6'h23;
		chk_out();
		conv(6'h00);
		wip = load(tbl[idx], initial_wiper_value, 1'b1);
		chk_out();
		wr(8'h03, 8'h00);
		wr(8'h0A, 8'h06);
		wr(8'h09, 8'h22);
		rd_chk(8'h09, 8'h00);
		conv(6'h05);
		chk_out();
		wr(8'h0A, 8'h00);
		wr(8'h03, 8'h03);
		wr(8'h0A, 8'h01);
		chk({7'h00, standby_o}, 8'h01);
		rd_chk(8'h0A, 8'h01);
		conv(6'h07);
		chk_out();
		wr(8'h0A, 8'h00);
		chk({7'h00, standby_o}, 8'h00);
		conv(6'h09);
		chk_out();
		conv(6'h09);
		idx = 6'h09;
		wip = load(tbl[9], initial_wiper_value, 1'b1);
		chk_out();
		give_verdict();
	end
endmodule
